// ==== testbench/cpu_ack_model.sv ====
`timescale 1ns/1ps
module cpu_ack_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       irq_req,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_dly,
  output logic            irq_ack
);
  logic [3:0] wait_ff;

  // acknowledges a presented request after ack_dly cycles, one-cycle pulse
  always_ff @(posedge mclk) begin
    if (!rst_n || !irq_req || irq_ack || !ack_en) begin
      wait_ff <= 4'h0;
      irq_ack <= 1'b0;
    end else if (wait_ff == ack_dly) begin
      irq_ack <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule

// ==== testbench/interrupt_flag_mapping_bench.sv ====
`timescale 1ns/1ps
module interrupt_flag_mapping_bench;
  import irq_types_pkg::*;
  logic        mclk, rst_n, ack_en, irq_ack, irq_req;
  logic [18:0] src;
  logic        uart0_error_irq_enable, uart1_error_irq_enable;
  logic [1:0]  external_pin_irq, pin_rising_edge_enables;
  logic [1:0]  pin_falling_edge_enables, isp, irq_lvl;
  logic [31:0] other_src_set, sw_set, sw_clr, flags;
  logic        mask_wr, prio0_wr, prio1_wr, irq_enable;
  logic [31:0] mask_wdata, prio0_wdata, prio1_wdata;
  logic [3:0]  ack_dly;
  logic [4:0]  irq_idx;
  logic [7:0]  request_flags_grp0_upper, request_flags_grp1_lower;
  logic [7:0]  request_flags_grp1_upper, request_flags_grp2_lower;
  logic [7:0]  mask_flags_grp0_upper, mask_flags_grp1_lower;
  int          mismatches, n_checks;
  int          tgt [19] = '{5, 5, 5, 8, 8, 9, 9, 11, 11, 16, 17, 18, 19, 20,
                            24, 25, 26, 30, 31};

  assign flags = {request_flags_grp2_lower, request_flags_grp1_upper,
                  request_flags_grp1_lower, request_flags_grp0_upper};

  interrupt_flag_mapping interrupt_flag_mapping_inst (
    .mclk, .rst_n, .serial0_tx_end_irq(src[0]),
    .clocked_serial00_end_irq(src[1]), .simple_i2c00_end_irq(src[2]),
    .uart0_rx_error_irq(src[3]), .uart0_error_irq_enable,
    .timer_ch1_upper8_irq(src[4]), .serial1_tx_end_irq(src[5]),
    .simple_i2c10_end_irq(src[6]), .uart1_rx_error_irq(src[7]),
    .uart1_error_irq_enable, .timer_ch3_upper8_irq(src[8]),
    .timer_ch2_irq(src[9]), .timer_ch3_irq(src[10]),
    .adc_conv_end_irq(src[11]), .rtc_event_irq(src[12]),
    .interval12_timer_irq(src[13]), .delta_sigma_conv_end_irq(src[14]),
    .timer_ch4_irq(src[15]), .timer_ch5_irq(src[16]),
    .external_pin_irq, .pin_rising_edge_enables, .pin_falling_edge_enables,
    .comparator0_irq(src[17]), .comparator1_irq(src[18]),
    .other_src_set, .sw_set, .sw_clr, .mask_wr, .mask_wdata, .prio0_wr,
    .prio0_wdata, .prio1_wr, .prio1_wdata, .irq_enable,
    .in_service_level_bit0(isp[0]), .in_service_level_bit1(isp[1]),
    .irq_ack, .request_flags_grp0_upper, .request_flags_grp1_lower,
    .request_flags_grp1_upper, .request_flags_grp2_lower,
    .mask_flags_grp0_upper, .mask_flags_grp1_lower, .irq_req, .irq_idx,
    .irq_lvl
  );

  cpu_ack_model cpu_ack_model_inst (
    .mclk, .rst_n, .irq_req, .ack_en, .ack_dly, .irq_ack
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one-cycle source pulse, then settle past the sampling edge
  task automatic fire(input int i);
    @(posedge mclk);
    src[i] <= 1'b1;
    @(posedge mclk);
    src[i] <= 1'b0;
    #1;
  endtask

  task automatic setclr(input logic [31:0] st, cl, oth);
    @(posedge mclk);
    sw_set <= st;
    sw_clr <= cl;
    other_src_set <= oth;
    @(posedge mclk);
    {sw_set, sw_clr, other_src_set} <= '0;
    #1;
  endtask

  task automatic ack(input logic [3:0] d);
    @(posedge mclk);
    ack_dly <= d;
    ack_en <= 1'b1;
    repeat (20) begin
      @(posedge mclk);
      if (irq_ack === 1'b1) break;
    end
    ack_en <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic pres(input logic [4:0] idx, input logic [1:0] lvl);
    chk("irq_req", 32'(irq_req), 32'h1);
    chk("irq_idx", 32'(irq_idx), 32'(idx));
    chk("irq_lvl", 32'(irq_lvl), 32'(lvl));
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    stop_test;
  end

  initial begin
    {src, sw_set, sw_clr, other_src_set, mask_wdata} = '0;
    {prio0_wdata, prio1_wdata, external_pin_irq, isp} = '0;
    {pin_rising_edge_enables, pin_falling_edge_enables, ack_dly} = '0;
    {uart0_error_irq_enable, uart1_error_irq_enable, mask_wr} = '0;
    {prio0_wr, prio1_wr, irq_enable, ack_en} = '0;
    rst_n = 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk("flags", flags, 32'h0);
    chk("masks", 32'({mask_flags_grp1_lower, mask_flags_grp0_upper}),
        32'hFFFF);
    chk("irq_req", 32'(irq_req), 32'h0);
    // each error interrupt enabled only in the iteration that fires its own uart error source
    for (int i = 0; i < 19; i++) begin
      @(posedge mclk);
      uart0_error_irq_enable <= (i == 3);
      uart1_error_irq_enable <= (i == 7);
      fire(i);
      chk("src", flags, 32'h1 << tgt[i]);
      setclr(32'h0, 32'h1 << tgt[i], 32'h0);
      chk("clr", flags, 32'h0);
    end
    @(posedge mclk);
    {uart0_error_irq_enable, uart1_error_irq_enable} <= 2'b00;
    fire(3);
    fire(7);
    chk("err gated", flags, 32'h0);
    setclr(32'hFFFFFFFF, 32'h0, 32'h0);
    chk("sw all", flags, 32'hDF1FFFE7);
    setclr(32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF);
    chk("other", flags, 32'h0000F4C7);
    setclr(32'h0, 32'hFFFFFFFF, 32'h0);
    @(posedge mclk);
    pin_rising_edge_enables <= 2'b10;
    pin_falling_edge_enables <= 2'b01;
    external_pin_irq <= 2'b11;
    @(posedge mclk);
    external_pin_irq <= 2'b00;
    #1;
    chk("pin rise", flags, 32'h10000000);
    @(posedge mclk);
    #1;
    chk("pin fall", flags, 32'h18000000);
    setclr(32'h0, 32'hFFFFFFFF, 32'h0);
    @(posedge mclk);
    mask_wr <= 1'b1;
    mask_wdata <= 32'hFFFCFFDF;
    prio0_wr <= 1'b1;
    prio0_wdata <= 32'hFFFDFFFF;
    prio1_wr <= 1'b1;
    prio1_wdata <= 32'hFFFCFFFF;
    isp <= 2'b11;
    @(posedge mclk);
    {mask_wr, prio0_wr, prio1_wr} <= 3'b000;
    setclr(32'h00070020, 32'h0, 32'h0);
    chk("masks", 32'({mask_flags_grp1_lower, mask_flags_grp0_upper}),
        32'hFFDF);
    chk("irq_req", 32'(irq_req), 32'h0);
    @(posedge mclk);
    irq_enable <= 1'b1;
    @(posedge mclk);
    #1;
    pres(5'd17, 2'd0);
    ack(4'h0);
    chk("ack", flags, 32'h00050020);
    pres(5'd16, 2'd1);
    @(posedge mclk);
    isp <= 2'b00;
    @(posedge mclk);
    #1;
    chk("isp block", 32'(irq_req), 32'h0);
    @(posedge mclk);
    isp <= 2'b11;
    ack(4'h3);
    pres(5'd5, 2'd3);
    ack(4'h1);
    chk("ack", flags, 32'h00040000);
    chk("irq_req", 32'(irq_req), 32'h0);
    // two sources on one level: the lower index goes first
    @(posedge mclk);
    prio0_wr <= 1'b1;
    prio0_wdata <= 32'hFFFCFFFF;
    @(posedge mclk);
    prio0_wr <= 1'b0;
    setclr(32'h00030000, 32'h0, 32'h0);
    pres(5'd16, 2'd0);
    ack(4'h0);
    chk("ack", flags, 32'h00060000);
    pres(5'd17, 2'd0);
    // reset in mid-run restores flags, masks and presentation
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk("flags", flags, 32'h0);
    chk("masks", 32'({mask_flags_grp1_lower, mask_flags_grp0_upper}),
        32'hFFFF);
    chk("irq_req", 32'(irq_req), 32'h0);
    stop_test;
  end
endmodule

// ==== verilog/interrupt_flag_mapping.sv ====
`timescale 1ns/1ps
`include "irq_flag_map.svh"
module interrupt_flag_mapping
  import irq_types_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        serial0_tx_end_irq,
  input  wire logic        clocked_serial00_end_irq,
  input  wire logic        simple_i2c00_end_irq,
  input  wire logic        uart0_rx_error_irq,
  input  wire logic        uart0_error_irq_enable,
  input  wire logic        timer_ch1_upper8_irq,
  input  wire logic        serial1_tx_end_irq,
  input  wire logic        simple_i2c10_end_irq,
  input  wire logic        uart1_rx_error_irq,
  input  wire logic        uart1_error_irq_enable,
  input  wire logic        timer_ch3_upper8_irq,
  input  wire logic        timer_ch2_irq,
  input  wire logic        timer_ch3_irq,
  input  wire logic        adc_conv_end_irq,
  input  wire logic        rtc_event_irq,
  input  wire logic        interval12_timer_irq,
  input  wire logic        delta_sigma_conv_end_irq,
  input  wire logic        timer_ch4_irq,
  input  wire logic        timer_ch5_irq,
  input  wire logic [1:0]  external_pin_irq,
  input  wire logic [1:0]  pin_rising_edge_enables,
  input  wire logic [1:0]  pin_falling_edge_enables,
  input  wire logic        comparator0_irq,
  input  wire logic        comparator1_irq,
  input  wire logic [31:0] other_src_set,
  input  wire logic [31:0] sw_set,
  input  wire logic [31:0] sw_clr,
  input  wire logic        mask_wr,
  input  wire logic [31:0] mask_wdata,
  input  wire logic        prio0_wr,
  input  wire logic [31:0] prio0_wdata,
  input  wire logic        prio1_wr,
  input  wire logic [31:0] prio1_wdata,
  input  wire logic        irq_enable,
  input  wire logic        in_service_level_bit0,
  input  wire logic        in_service_level_bit1,
  input  wire logic        irq_ack,
  output logic [7:0]       request_flags_grp0_upper,
  output logic [7:0]       request_flags_grp1_lower,
  output logic [7:0]       request_flags_grp1_upper,
  output logic [7:0]       request_flags_grp2_lower,
  output logic [7:0]       mask_flags_grp0_upper,
  output logic [7:0]       mask_flags_grp1_lower,
  output logic             irq_req,
  output logic [4:0]       irq_idx,
  output logic [1:0]       irq_lvl
);

  flag_state_t state_ff;
  flag_state_t nxt_state;
  logic [31:0] hw_set;
  logic [31:0] req_cleared;
  logic [31:0] nxt_req;
  logic [31:0] nxt_mask;
  logic [31:0] nxt_pr0;
  logic [31:0] nxt_pr1;
  logic [1:0]  pin_edge;
  logic [1:0]  isp;
  logic        res_found;
  logic [4:0]  res_idx;
  logic [1:0]  res_lvl;

  assign isp = {in_service_level_bit1, in_service_level_bit0};

  // pin edge detect with per-pin rising and falling enables
  assign pin_edge = (external_pin_irq & ~state_ff.pin_prev
                     & pin_rising_edge_enables)
                  | (~external_pin_irq & state_ff.pin_prev
                     & pin_falling_edge_enables);

  always_comb begin
    hw_set = other_src_set & `OTHER_BITS;
    hw_set[`BIT_G0H_SHARED5] = serial0_tx_end_irq
                             | clocked_serial00_end_irq
                             | simple_i2c00_end_irq;
    hw_set[`BIT_G1L_SHARED0] = (uart0_rx_error_irq & uart0_error_irq_enable)
                             | timer_ch1_upper8_irq;
    hw_set[`BIT_G1L_SHARED1] = serial1_tx_end_irq
                             | simple_i2c10_end_irq;
    hw_set[`BIT_G1L_SHARED3] = (uart1_rx_error_irq & uart1_error_irq_enable)
                             | timer_ch3_upper8_irq;
    hw_set[`BIT_G1H_TMR2] = timer_ch2_irq;
    hw_set[`BIT_G1H_TMR3] = timer_ch3_irq;
    hw_set[`BIT_G1H_ADC]  = adc_conv_end_irq;
    hw_set[`BIT_G1H_RTC]  = rtc_event_irq;
    hw_set[`BIT_G1H_ITMR] = interval12_timer_irq;
    hw_set[`BIT_G2L_DSAD] = delta_sigma_conv_end_irq;
    hw_set[`BIT_G2L_TMR4] = timer_ch4_irq;
    hw_set[`BIT_G2L_TMR5] = timer_ch5_irq;
    hw_set[`BIT_G2L_PIN6] = pin_edge[0];
    hw_set[`BIT_G2L_PIN7] = pin_edge[1];
    hw_set[`BIT_G2L_CMP0] = comparator0_irq;
    hw_set[`BIT_G2L_CMP1] = comparator1_irq;
  end

  // next flag, mask and priority vectors, kept apart from the state copy
  // so the resolver result does not loop back into its own inputs
  always_comb begin
    req_cleared = state_ff.req & ~sw_clr;
    if (irq_ack && state_ff.irq_req) begin
      req_cleared[state_ff.irq_idx] = 1'b0;
    end
    // set wins over any clear in the same cycle
    nxt_req  = (req_cleared | hw_set | sw_set) & `VALID_BITS;
    nxt_mask = mask_wr ? mask_wdata : state_ff.mask;
    nxt_pr0  = prio0_wr ? prio0_wdata : state_ff.pr0;
    nxt_pr1  = prio1_wr ? prio1_wdata : state_ff.pr1;
    if (!rst_n) begin
      nxt_req  = `REQ_RESET;
      nxt_mask = `MASK_RESET;
      nxt_pr0  = `PRIO_RESET;
      nxt_pr1  = `PRIO_RESET;
    end
  end

  // one request, mask and priority pair per flat position
  always_comb begin
    nxt_state          = state_ff;
    nxt_state.req      = nxt_req;
    nxt_state.mask     = nxt_mask;
    nxt_state.pr0      = nxt_pr0;
    nxt_state.pr1      = nxt_pr1;
    nxt_state.pin_prev = external_pin_irq;
    nxt_state.irq_req  = res_found;
    nxt_state.irq_idx  = res_idx;
    nxt_state.irq_lvl  = res_lvl;
    if (!rst_n) begin
      nxt_state.pin_prev = 2'h0;
      nxt_state.irq_req  = 1'b0;
      nxt_state.irq_idx  = 5'h00;
      nxt_state.irq_lvl  = 2'h3;
    end
  end

  always_ff @(posedge mclk) begin
    state_ff <= nxt_state;
  end

  prio_resolver #(
    .N (`FLAG_COUNT)
  ) u_resolver (
    .req   (nxt_req),
    .mask  (nxt_mask),
    .pr0   (nxt_pr0),
    .pr1   (nxt_pr1),
    .isp   (isp),
    .ie    (irq_enable),
    .found (res_found),
    .idx   (res_idx),
    .lvl   (res_lvl)
  );

  assign request_flags_grp0_upper = state_ff.req[7:0];
  assign request_flags_grp1_lower = state_ff.req[15:8];
  assign request_flags_grp1_upper = state_ff.req[23:16];
  assign request_flags_grp2_lower = state_ff.req[31:24];
  assign mask_flags_grp0_upper    = state_ff.mask[7:0];
  assign mask_flags_grp1_lower    = state_ff.mask[15:8];
  assign irq_req                  = state_ff.irq_req;
  assign irq_idx                  = state_ff.irq_idx;
  assign irq_lvl                  = state_ff.irq_lvl;

  sequence s_ack_taken;
    irq_ack && state_ff.irq_req && !hw_set[state_ff.irq_idx]
      && !sw_set[state_ff.irq_idx];
  endsequence

  sequence s_flag_gone;
    !state_ff.req[$past(state_ff.irq_idx)];
  endsequence

  chk_reset_values: assert property (
    @(posedge mclk) $rose(rst_n) |->
      state_ff.req == 32'h00000000 && state_ff.mask == 32'hFFFFFFFF)
    else $error("reset values of flags or masks wrong");

  chk_shared_bit5: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (serial0_tx_end_irq || clocked_serial00_end_irq
     || simple_i2c00_end_irq) |=> state_ff.req[5])
    else $error("shared bit 5 not set");

  chk_g1l_bit0_set: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (timer_ch1_upper8_irq || (uart0_rx_error_irq && uart0_error_irq_enable))
      |=> state_ff.req[8])
    else $error("group1 lower bit 0 not set");

  chk_uart0_gated: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!state_ff.req[8] && !timer_ch1_upper8_irq && !uart0_error_irq_enable
     && !other_src_set[8] && !sw_set[8]) |=> !state_ff.req[8])
    else $error("disabled uart0 error set the shared flag");

  chk_g1l_bit1_set: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (serial1_tx_end_irq || simple_i2c10_end_irq) |=> state_ff.req[9])
    else $error("group1 lower bit 1 not set");

  chk_g1l_bit3_set: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (timer_ch3_upper8_irq || (uart1_rx_error_irq && uart1_error_irq_enable))
      |=> state_ff.req[11])
    else $error("group1 lower bit 3 not set");

  chk_ack_clears: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_ack_taken |=> s_flag_gone)
    else $error("acknowledged flag not cleared");

  chk_reserved_zero: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (state_ff.req & ~32'hDF1FFFE7) == 32'h00000000)
    else $error("reserved request bit set");

  chk_level_gate: assert property (
    @(posedge mclk) disable iff (!rst_n)
    irq_req |-> irq_lvl <= $past(isp) && $past(irq_enable)
      && !state_ff.mask[irq_idx])
    else $error("request presented above in-service level");

endmodule

// ==== verilog/irq_flag_map.svh ====
`ifndef IRQ_FLAG_MAP_SVH
`define IRQ_FLAG_MAP_SVH

// flat flag index: group0 upper 0..7, group1 lower 8..15,
// group1 upper 16..23, group2 lower 24..31
`define FLAG_COUNT       32
`define BIT_G0H_SHARED5  5
`define BIT_G1L_SHARED0  8
`define BIT_G1L_SHARED1  9
`define BIT_G1L_SHARED3  11
`define BIT_G1H_TMR2     16
`define BIT_G1H_TMR3     17
`define BIT_G1H_ADC      18
`define BIT_G1H_RTC      19
`define BIT_G1H_ITMR     20
`define BIT_G2L_DSAD     24
`define BIT_G2L_TMR4     25
`define BIT_G2L_TMR5     26
`define BIT_G2L_PIN6     27
`define BIT_G2L_PIN7     28
`define BIT_G2L_CMP0     30
`define BIT_G2L_CMP1     31
`define VALID_BITS       32'hDF1FFFE7
`define OTHER_BITS       32'h0000F4C7
`define REQ_RESET        32'h00000000
`define MASK_RESET       32'hFFFFFFFF
`define PRIO_RESET       32'hFFFFFFFF

`endif

// ==== verilog/irq_types_pkg.sv ====
package irq_types_pkg;

  typedef struct packed {
    logic [31:0] req;
    logic [31:0] mask;
    logic [31:0] pr0;
    logic [31:0] pr1;
    logic [1:0]  pin_prev;
    logic        irq_req;
    logic [4:0]  irq_idx;
    logic [1:0]  irq_lvl;
  } flag_state_t;

endpackage

// ==== verilog/prio_resolver.sv ====
`timescale 1ns/1ps
module prio_resolver #(
  parameter int N = 32
) (
  input  wire logic [N-1:0]         req,
  input  wire logic [N-1:0]         mask,
  input  wire logic [N-1:0]         pr0,
  input  wire logic [N-1:0]         pr1,
  input  wire logic [1:0]           isp,
  input  wire logic                 ie,
  output logic                      found,
  output logic [$clog2(N)-1:0]      idx,
  output logic [1:0]                lvl
);

  function automatic logic [1:0] level_of(input logic p1, input logic p0);
    level_of = {p1, p0};
  endfunction

  // lowest level wins, then lowest index (default order)
  always_comb begin
    found = 1'b0;
    idx   = '0;
    lvl   = 2'h3;
    for (int l = 3; l >= 0; l--) begin
      for (int i = N - 1; i >= 0; i--) begin
        if (ie && req[i] && !mask[i] &&
            level_of(pr1[i], pr0[i]) == 2'(l) &&
            level_of(pr1[i], pr0[i]) <= isp) begin
          found = 1'b1;
          idx   = ($clog2(N))'(i);
          lvl   = 2'(l);
        end
      end
    end
  end

endmodule
